// *** logic/serial_dac_input_interface.sv ***
`timescale 1ns/1ps
module serial_dac_input_interface import dac_serial_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Host pins
    input wire logic ser_clk_pin,
    input wire logic data_in_pin,
    input wire logic latch_pin,
    input wire logic force_low_pin,
    input wire logic [1:0] range_sel_pin,
    input wire logic async_mode_pin,
    // Serial output pin
    output logic data_out,
    // Converter side
    input wire logic dac_ready,
    output logic [WORD_BITS-1:0] dac_code,
    output logic [WORD_BITS-1:0] held_code,
    output logic at_bottom,
    output span_type span,
    // Status pulses
    output logic word_loaded,
    output logic framing_error,
    output logic overrun
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] filt;
        logic [PIN_COUNT-1:0] prev;
        rx_state_type rx;
        logic [CNT_BITS-1:0] cnt;
        logic [WORD_BITS-1:0] rx_shift;
        logic [WORD_BITS-1:0] tw_shift;
        logic pend_valid;
        logic [WORD_BITS-1:0] pend_word;
        logic [WORD_BITS-1:0] held;
        logic [WORD_BITS-1:0] code_out;
        logic bottom;
        span_type span;
        logic data_out;
        logic word_loaded;
        logic framing_error;
        logic overrun;
    } core_state_type;

    core_state_type st;
    core_state_type next_st;

    // ****************************************
    // Buffer between receiver and converter
    // ****************************************
    word_if fill_ch ();
    word_if drain_ch ();

    word_buffer u_word_buffer (
        .core_clk (core_clk),
        .resetn (resetn),
        .fill (fill_ch.snk),
        .drain (drain_ch.src)
    );

    // Pending word is offered until the buffer takes it
    assign fill_ch.valid = st.pend_valid;
    assign fill_ch.data = st.pend_word;
    // Converter stall holds words in the buffer
    assign drain_ch.ready = dac_ready;

    // ****************************************
    // Pin sampling
    // ****************************************
    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] agreed;

    // Gather the host pins into one vector
    always_comb begin
        pins = '0;
        pins[PIN_SCLK] = ser_clk_pin;
        pins[PIN_DIN] = data_in_pin;
        pins[PIN_LATCH] = latch_pin;
        pins[PIN_FORCE] = force_low_pin;
        pins[PIN_RANGE0] = range_sel_pin[0];
        pins[PIN_RANGE1] = range_sel_pin[1];
        pins[PIN_MODE] = async_mode_pin;
    end

    // A pin change counts once the second and third stages agree
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_filter
        assign agreed[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.filt[i];
    end

    // ****************************************
    // Edge and level decode
    // ****************************************
    logic sclk_rise;
    logic latch_rise;
    logic din_fall;
    logic din;
    logic async_mode;
    logic mode_change;

    assign sclk_rise = st.filt[PIN_SCLK] && !st.prev[PIN_SCLK];
    assign latch_rise = st.filt[PIN_LATCH] && !st.prev[PIN_LATCH];
    assign din_fall = !st.filt[PIN_DIN] && st.prev[PIN_DIN];
    assign din = st.filt[PIN_DIN];
    assign async_mode = st.filt[PIN_MODE];
    assign mode_change = st.filt[PIN_MODE] != st.prev[PIN_MODE];

    // ****************************************
    // Next state
    // ****************************************
    logic new_word;
    logic [WORD_BITS-1:0] new_data;
    logic accepted;

    always_comb begin
        next_st = st;
        new_word = 1'b0;
        new_data = st.rx_shift;
        accepted = st.pend_valid && fill_ch.ready;

        // Synchroniser chain and filtered levels
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.filt = agreed;
        next_st.prev = st.filt;

        // Pulses last one core cycle
        next_st.word_loaded = 1'b0;
        next_st.framing_error = 1'b0;
        next_st.overrun = 1'b0;

        if (mode_change) begin
            // Switching modes abandons any frame in flight
            next_st.rx = rx_idle;
            next_st.data_out = 1'b0;
        end else if (async_mode) begin
            // Error pulse ends at the next input clock rise
            if (sclk_rise) begin
                next_st.data_out = 1'b0;
            end
            case (st.rx)
                rx_idle: begin
                    // Start cell begins at the next input clock rise
                    if (din_fall) begin
                        next_st.rx = rx_frame;
                        next_st.cnt = '0;
                    end
                end
                rx_frame: begin
                    if (sclk_rise) begin
                        next_st.cnt = st.cnt + CNT_STEP;
                        // Sample only at the centre of each 16-clock cell
                        if (st.cnt[3:0] == CELL_CENTRE) begin
                            if (st.cnt == START_SAMPLE) begin
                                // A start bit that is not low was a glitch
                                if (din != START_LEVEL) begin
                                    next_st.rx = rx_idle;
                                end
                            end else if (st.cnt == STOP_SAMPLE) begin
                                next_st.rx = rx_idle;
                                if (din == STOP_LEVEL) begin
                                    new_word = 1'b1;
                                    new_data = st.rx_shift;
                                end else begin
                                    // Bad stop bit: flag it, drop the word
                                    next_st.data_out = 1'b1;
                                    next_st.framing_error = 1'b1;
                                end
                            end else begin
                                // Top bit at 24, second at 40, then every 16
                                next_st.rx_shift = {st.rx_shift[WORD_BITS-2:0], din};
                            end
                        end
                    end
                end
                default: begin
                    next_st.rx = rx_idle;
                end
            endcase
        end else begin
            next_st.rx = rx_idle;
            // Three-wire shift, top bit first, last 16 bits kept
            if (sclk_rise) begin
                next_st.tw_shift = {st.tw_shift[WORD_BITS-2:0], din};
            end
            // Bit leaving the register drives the chain output
            next_st.data_out = next_st.tw_shift[WORD_BITS-1];
            // Load strobe copies the whole register at once
            if (latch_rise) begin
                new_word = 1'b1;
                new_data = st.tw_shift;
            end
        end

        // Hand-off into the buffer; an older pending word is kept
        if (accepted) begin
            next_st.pend_valid = 1'b0;
        end
        if (new_word) begin
            if (next_st.pend_valid) begin
                next_st.overrun = 1'b1;
            end else begin
                next_st.pend_valid = 1'b1;
                next_st.pend_word = new_data;
            end
        end

        // Converter takes a buffered word; releases the bottom hold
        if (drain_ch.valid && dac_ready) begin
            next_st.held = drain_ch.data;
            next_st.word_loaded = 1'b1;
            next_st.bottom = 1'b0;
        end

        // Force-low pins the output at span minimum, code untouched
        if (st.filt[PIN_FORCE]) begin
            next_st.bottom = 1'b1;
        end

        // Driven code is bottom of span until a new word loads
        next_st.code_out = next_st.bottom ? BOTTOM_CODE : next_st.held;

        // Range select decodes straight to the span
        next_st.span = span_type'({st.filt[PIN_RANGE1], st.filt[PIN_RANGE0]});
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st <= '0;
            st.rx <= rx_idle;
            st.held <= RESET_CODE;
            st.code_out <= BOTTOM_CODE;
            st.bottom <= 1'b1;
            st.span <= range_volt_0_5;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign data_out = st.data_out;
    assign dac_code = st.code_out;
    assign held_code = st.held;
    assign at_bottom = st.bottom;
    assign span = st.span;
    assign word_loaded = st.word_loaded;
    assign framing_error = st.framing_error;
    assign overrun = st.overrun;

endmodule : serial_dac_input_interface

// *** logic/dac_serial_pkg.sv ***
package dac_serial_pkg;

    // ****************************************
    // Word and framing
    // ****************************************
    localparam int WORD_BITS = 16;
    localparam int CNT_BITS = 9;
    localparam logic START_LEVEL = 1'b0;
    localparam logic STOP_LEVEL = 1'b1;
    localparam logic [3:0] CELL_CENTRE = 4'h8;
    localparam logic [CNT_BITS-1:0] START_SAMPLE = 9'h008;
    localparam logic [CNT_BITS-1:0] FIRST_DATA_SAMPLE = 9'h018;
    localparam logic [CNT_BITS-1:0] SECOND_DATA_SAMPLE = 9'h028;
    localparam logic [CNT_BITS-1:0] STOP_SAMPLE = 9'h118;
    localparam logic [CNT_BITS-1:0] CNT_STEP = 9'h001;

    // ****************************************
    // Reset values and codes
    // ****************************************
    localparam logic [WORD_BITS-1:0] BOTTOM_CODE = 16'h0000;
    localparam logic [WORD_BITS-1:0] RESET_CODE = 16'h0000;

    // ****************************************
    // Pin sampling
    // ****************************************
    localparam int PIN_COUNT = 7;
    localparam int PIN_SCLK = 0;
    localparam int PIN_DIN = 1;
    localparam int PIN_LATCH = 2;
    localparam int PIN_FORCE = 3;
    localparam int PIN_RANGE0 = 4;
    localparam int PIN_RANGE1 = 5;
    localparam int PIN_MODE = 6;

    // ****************************************
    // Buffer
    // ****************************************
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BUF_STEP = 2'h1;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        range_volt_0_5 = 2'h0,
        range_ma_4_20 = 2'h1,
        range_ma_0_20 = 2'h2,
        range_ma_0_24 = 2'h3
    } span_type;

    typedef enum logic [1:0] {
        rx_idle = 2'h1,
        rx_frame = 2'h2
    } rx_state_type;

endpackage : dac_serial_pkg

// *** logic/word_if.sv ***
`timescale 1ns/1ps
// Valid/ready word channel between receiver, buffer and converter side
interface word_if import dac_serial_pkg::*; ();
    logic valid;
    logic ready;
    logic [WORD_BITS-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : word_if

// *** logic/word_buffer.sv ***
`timescale 1ns/1ps
module word_buffer import dac_serial_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Filling side
    word_if.snk fill,
    // Draining side
    word_if.src drain
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [BUF_DEPTH-1:0][WORD_BITS-1:0] entry;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } buf_state_type;

    buf_state_type st;
    buf_state_type next_st;
    logic push;
    logic pop;

    // Handshake outputs come from the registered count and entries
    assign fill.ready = (st.count != BUF_FULL);
    assign drain.valid = (st.count != BUF_EMPTY);
    assign drain.data = st.entry[st.rd_ptr];
    assign push = fill.valid && (st.count != BUF_FULL);
    assign pop = drain.ready && (st.count != BUF_EMPTY);

    // Pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.entry[st.wr_ptr] = fill.data;
            next_st.wr_ptr = ~st.wr_ptr;
        end
        if (pop) begin
            next_st.rd_ptr = ~st.rd_ptr;
        end
        if (push && !pop) begin
            next_st.count = st.count + BUF_STEP;
        end else if (pop && !push) begin
            next_st.count = st.count - BUF_STEP;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : word_buffer

// *** testbench/serial_dac_input_interface_chk.sv ***
`timescale 1ns/1ps
module serial_dac_input_interface_chk import dac_serial_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Watched ports
    input wire logic force_low_pin,
    input wire logic [1:0] range_sel_pin,
    input wire logic data_out,
    input wire logic [WORD_BITS-1:0] dac_code,
    input wire logic [WORD_BITS-1:0] held_code,
    input wire logic at_bottom,
    input wire span_type span,
    input wire logic word_loaded,
    input wire logic framing_error
);
    // ****************************************
    // Clocking and sequences
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Output pulse with or one cycle after the error flag, and no load for four cycles after a bad frame
    sequence s_err_out;
        ##[0:1] data_out;
    endsequence
    sequence s_no_load;
        ##1 !word_loaded [*4];
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    a_bottom_zero_code:
        assert property (at_bottom |-> dac_code == BOTTOM_CODE) else $error("code not at bottom");
    a_force_to_bottom:
        assert property ($rose(force_low_pin) |-> ##[1:8] at_bottom) else $error("force ignored");
    a_held_only_load:
        assert property ($changed(held_code) |-> word_loaded) else $error("held code moved");
    a_bottom_until_load:
        assert property ($fell(at_bottom) |-> word_loaded) else $error("bottom left early");
    a_loaded_to_out:
        assert property (word_loaded && !at_bottom |-> dac_code == held_code)
            else $error("code not passed on");
    a_err_one_clock:
        assert property (framing_error |=> !framing_error) else $error("error pulse too long");
    a_err_drives_out:
        assert property (framing_error |-> s_err_out) else $error("no serial error pulse");
    a_err_no_load:
        assert property (framing_error |-> s_no_load) else $error("bad word loaded");
    a_span_follows:
        assert property ($stable(range_sel_pin) [*8] |-> span == range_sel_pin)
            else $error("span mismatch");
endmodule : serial_dac_input_interface_chk

bind serial_dac_input_interface serial_dac_input_interface_chk i_chk (
    .core_clk(core_clk), .resetn(resetn), .force_low_pin(force_low_pin),
    .range_sel_pin(range_sel_pin), .data_out(data_out), .dac_code(dac_code),
    .held_code(held_code), .at_bottom(at_bottom), .span(span),
    .word_loaded(word_loaded), .framing_error(framing_error)
);

// *** testbench/host_model.sv ***
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic core_clk,
    // Host pins
    output logic ser_clk_pin,
    output logic data_in_pin,
    output logic latch_pin
);
    int ph = 3; // Core cycles per input clock phase

    // Clock parked low, data line idle high
    initial begin
        ser_clk_pin = 1'b0;
        data_in_pin = 1'b1;
        latch_pin = 1'b0;
    end

    // One input clock period, low then high; stands low afterwards
    task automatic pulse();
        repeat (ph) @(posedge core_clk);
        ser_clk_pin <= 1'b1;
        repeat (ph) @(posedge core_clk);
        ser_clk_pin <= 1'b0;
    endtask : pulse

    // Three-wire word, strobe low while shifting, clock low while strobing
    task automatic send3(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            data_in_pin <= w[i];
            pulse();
        end
        data_in_pin <= ~w[0]; // Released line shows no stale bit
        repeat (ph) @(posedge core_clk);
        latch_pin <= 1'b1;
        repeat (ph) @(posedge core_clk);
        latch_pin <= 1'b0;
    endtask : send3

    // Framed word: start bit, 16 data bits top first, chosen stop level
    task automatic send_async(input logic [15:0] w, input logic stop);
        logic [17:0] f;
        f = {1'b0, w, stop};
        for (int k = 0; k < 281; k++) begin
            data_in_pin <= f[17 - k / 16];
            pulse();
        end
        data_in_pin <= 1'b1; // Idle high between words
    endtask : send_async
endmodule : host_model

// *** testbench/serial_dac_input_interface_bench.sv ***
`timescale 1ns/1ps
module serial_dac_input_interface_bench import dac_serial_pkg::*; ;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic core_clk, resetn, ser_clk_pin, data_in_pin, latch_pin, force_low_pin;
    logic async_mode_pin, dac_ready, data_out, at_bottom, word_loaded;
    logic framing_error, overrun;
    logic [1:0] range_sel_pin;
    logic [WORD_BITS-1:0] dac_code, held_code;
    span_type span;
    logic ovr_seen = 1'b0;
    logic ferr_seen = 1'b0;
    int err_count = 0;
    int n_tests = 0;
    logic [15:0] w [4] = '{16'hc35a, 16'h1e87, 16'hb0f1, 16'h6d24};

    host_model i_host (.core_clk(core_clk), .ser_clk_pin(ser_clk_pin),
        .data_in_pin(data_in_pin), .latch_pin(latch_pin));

    serial_dac_input_interface i_serial_dac_input_interface (
        .core_clk(core_clk), .resetn(resetn), .ser_clk_pin(ser_clk_pin),
        .data_in_pin(data_in_pin), .latch_pin(latch_pin), .force_low_pin(force_low_pin),
        .range_sel_pin(range_sel_pin), .async_mode_pin(async_mode_pin),
        .data_out(data_out), .dac_ready(dac_ready), .dac_code(dac_code),
        .held_code(held_code), .at_bottom(at_bottom), .span(span),
        .word_loaded(word_loaded), .framing_error(framing_error), .overrun(overrun));

    // Clock generator
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Sticky capture of one-cycle status pulses
    always @(posedge core_clk) begin
        if (overrun === 1'b1) ovr_seen <= 1'b1;
        if (framing_error === 1'b1) ferr_seen <= 1'b1;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // Wait for a load, bounded, then compare the held word
    task automatic wait_load(input logic [15:0] exp);
        int n;
        n = 0;
        @(posedge core_clk);
        while (word_loaded !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        check({15'h0, word_loaded}, 16'h0001);
        check(held_code, exp);
    endtask : wait_load

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_three_wire();
        i_host.send3(w[0]);
        check({15'h0, data_out}, {15'h0, w[0][15]});
        wait_load(w[0]);
        check(dac_code, w[0]);
    endtask : t_three_wire

    // Converter stalls: two buffered, one pending, the fourth is lost
    task automatic t_stall();
        dac_ready <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            i_host.send3(w[i]);
            check({15'h0, data_out}, {15'h0, w[i][15]});
        end
        cyc(12);
        check({15'h0, ovr_seen}, 16'h0001);
        dac_ready <= 1'b1;
        for (int i = 0; i < 3; i++) wait_load(w[i]);
        cyc(20);
        check(held_code, w[2]);
    endtask : t_stall

    task automatic t_async();
        async_mode_pin <= 1'b1;
        cyc(10);
        i_host.ph = 6;
        i_host.send_async(16'h3c96, 1'b1);
        wait_load(16'h3c96);
        i_host.ph = 3;
        i_host.send_async(16'h1234, 1'b0);
        cyc(12);
        check({15'h0, ferr_seen}, 16'h0001);
        check({15'h0, data_out}, 16'h0001);
        check(held_code, 16'h3c96);
        check(dac_code, 16'h3c96);
        i_host.send_async(16'h8001, 1'b1);
        wait_load(16'h8001);
        async_mode_pin <= 1'b0;
        cyc(10);
    endtask : t_async

    task automatic t_force();
        force_low_pin <= 1'b1;
        cyc(10);
        check(dac_code, BOTTOM_CODE);
        check(held_code, 16'h8001);
        force_low_pin <= 1'b0;
        cyc(10);
        check(dac_code, BOTTOM_CODE);
        check({15'h0, at_bottom}, 16'h0001);
        i_host.send3(16'h7e11);
        wait_load(16'h7e11);
        check(dac_code, 16'h7e11);
    endtask : t_force

    task automatic t_range();
        for (int r = 0; r < 4; r++) begin
            range_sel_pin <= r[1:0];
            cyc(10);
            check({14'h0, span}, {14'h0, r[1:0]});
        end
    endtask : t_range

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        resetn = 1'b0;
        force_low_pin = 1'b0;
        range_sel_pin = 2'h0;
        async_mode_pin = 1'b0;
        dac_ready = 1'b1;
        cyc(16);
        resetn <= 1'b1;
        cyc(10);
        check({15'h0, at_bottom}, 16'h0001);
        check(dac_code, BOTTOM_CODE);
        t_three_wire();
        t_stall();
        t_async();
        t_force();
        t_range();
        tally_and_finish();
    end

    initial begin
        cyc(30000);
        err_count++;
        tally_and_finish();
    end
endmodule : serial_dac_input_interface_bench
